// [hdl/spd_core.sv]
/*
  Stepper phase/current decode: per-channel bridge polarity and current
  level, standby gating, thermal and overcurrent latches, power-on hold-off,
  plus a classic Wishbone register slave with a sticky interrupt.
  Assumes pin inputs asynchronous to clk_i; single 100 MHz clock.
*/
// Chosen here: the Wishbone interface to the registers and the register offsets.
// Summary of operation
// R1: level pins: 11 full, 10 is 71 percent, 01 is 38 percent, 00 off.
// R2: both level pins low puts that channel's bridge in high impedance.
// R3: direction high drives positive high, negative low; low reverses it.
// R4: standby low stops the chop oscillator and disables every output.
// R5: controller applies direction and level only once motor supply is up.
// R6: thermal indication turns all outputs off and latches that state.
// R7: thermal latch clears only by power cycle or standby high-low-high.
// R8: outputs forced off while the supply monitor reports undervoltage.
// R9: overcurrent indication forces outputs off and holds that state.
// R10: overcurrent latch clears only by standby high-low-high or power cycle.
// R11: while overcurrent latched, behave as standby: oscillator and outputs stopped.
// R12: standby rising edge after low clears both fault latches together.
`timescale 1ns/100ps
module spd_core
  import spd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // pins from controller and analog monitors
  input wire logic chan_a_dir_i,
  input wire logic chan_a_level_sel_hi_i,
  input wire logic chan_a_level_sel_lo_i,
  input wire logic chan_b_dir_i,
  input wire logic chan_b_level_sel_hi_i,
  input wire logic chan_b_level_sel_lo_i,
  input wire logic standby_n_i,
  input wire logic therm_trip_i,
  input wire logic overcur_trip_i,
  input wire logic supply_low_i,
  // bridge drives, with enables for high impedance
  output logic chan_a_pos_out_o,
  output logic chan_a_neg_out_o,
  output logic chan_a_oe_o,
  output logic chan_b_pos_out_o,
  output logic chan_b_neg_out_o,
  output logic chan_b_oe_o,
  output logic [1:0] chan_a_level_o,
  output logic [1:0] chan_b_level_o,
  output logic chop_oscillator_en_o,
  output logic irq_o,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int NPIN = 10;

  function automatic spd_level_e level_decode(input logic hi, input logic lo);
    level_decode = spd_level_e'({hi, lo}); // R1
  endfunction : level_decode

  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  logic [NPIN-1:0] raw_pins;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] sync3_ff;
  logic [NPIN-1:0] pin_ff;
  logic [NPIN-1:0] nxt_pin;

  assign raw_pins = {supply_low_i, overcur_trip_i, therm_trip_i, standby_n_i,
                     chan_b_level_sel_lo_i, chan_b_level_sel_hi_i, chan_b_dir_i,
                     chan_a_level_sel_lo_i, chan_a_level_sel_hi_i, chan_a_dir_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      nxt_pin[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : pin_ff[i];
    end
  end

  // supply-low resets asserted, but the zeroed synchroniser stages clear it on the first cycle after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= {1'b1, {(NPIN-1){1'b0}}};
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  logic a_dir;
  logic b_dir;
  logic stby_n;
  logic therm_in;
  logic ocur_in;
  logic sup_low;
  spd_level_e a_lvl;
  spd_level_e b_lvl;

  assign a_dir = pin_ff[0];
  assign b_dir = pin_ff[3];
  assign stby_n = pin_ff[6];
  assign therm_in = pin_ff[7];
  assign ocur_in = pin_ff[8];
  assign sup_low = pin_ff[9];
  assign a_lvl = level_decode(pin_ff[1], pin_ff[2]);
  assign b_lvl = level_decode(pin_ff[4], pin_ff[5]);

  // software standby; the block runs only when pin and register both say run
  logic [31:0] ctrl_ff;
  logic stby_eff;
  logic stby_eff_d_ff;
  logic stby_release;

  assign stby_eff = stby_n & ctrl_ff[SPD_CTRL_STANDBY_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stby_eff_d_ff <= 1'b0;
    end else begin
      stby_eff_d_ff <= stby_eff;
    end
  end

  assign stby_release = stby_eff & ~stby_eff_d_ff; // R12

  // fault latches; the trip input wins over the release edge
  logic thermal_trip_latch_ff;
  logic overcurrent_latch_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thermal_trip_latch_ff <= 1'b0;
    end else if (therm_in) begin
      thermal_trip_latch_ff <= 1'b1; // R6
    end else if (stby_release) begin
      thermal_trip_latch_ff <= 1'b0; // R7
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overcurrent_latch_ff <= 1'b0;
    end else if (ocur_in) begin
      overcurrent_latch_ff <= 1'b1; // R9
    end else if (stby_release) begin
      overcurrent_latch_ff <= 1'b0; // R10
    end
  end

  logic run;
  logic a_on;
  logic b_on;

  assign run = stby_eff & ~overcurrent_latch_ff & ~thermal_trip_latch_ff & ~sup_low; // R4 R8 R11
  assign a_on = run & (a_lvl != SPD_LVL_OFF); // R2
  assign b_on = run & (b_lvl != SPD_LVL_OFF); // R2

  // registered bridge outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_a_pos_out_o <= 1'b0;
      chan_a_neg_out_o <= 1'b0;
      chan_a_oe_o <= 1'b0;
      chan_a_level_o <= SPD_LVL_OFF;
    end else begin
      chan_a_oe_o <= a_on; // R2
      chan_a_pos_out_o <= a_on & a_dir; // R3
      chan_a_neg_out_o <= a_on & ~a_dir; // R3
      chan_a_level_o <= a_on ? a_lvl : SPD_LVL_OFF; // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_b_pos_out_o <= 1'b0;
      chan_b_neg_out_o <= 1'b0;
      chan_b_oe_o <= 1'b0;
      chan_b_level_o <= SPD_LVL_OFF;
    end else begin
      chan_b_oe_o <= b_on; // R2
      chan_b_pos_out_o <= b_on & b_dir; // R3
      chan_b_neg_out_o <= b_on & ~b_dir; // R3
      chan_b_level_o <= b_on ? b_lvl : SPD_LVL_OFF; // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chop_oscillator_en_o <= 1'b0;
    end else begin
      chop_oscillator_en_o <= run; // R4 R11
    end
  end

  // interrupts: rising edges of the fault conditions
  logic therm_d_ff;
  logic ocur_d_ff;
  logic por_d_ff;
  logic [SPD_IRQ_W-1:0] irq_evt;
  logic [SPD_IRQ_W-1:0] irq_stat_ff;
  logic [SPD_IRQ_W-1:0] irq_en_ff;
  logic [SPD_IRQ_W-1:0] irq_clr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      therm_d_ff <= 1'b0;
      ocur_d_ff <= 1'b0;
      por_d_ff <= 1'b1;
    end else begin
      therm_d_ff <= thermal_trip_latch_ff;
      ocur_d_ff <= overcurrent_latch_ff;
      por_d_ff <= sup_low;
    end
  end

  always_comb begin
    irq_evt = SPD_IRQ_RST;
    irq_evt[SPD_IRQ_THERM_BIT] = thermal_trip_latch_ff & ~therm_d_ff;
    irq_evt[SPD_IRQ_OVERCUR_BIT] = overcurrent_latch_ff & ~ocur_d_ff;
    irq_evt[SPD_IRQ_POR_BIT] = sup_low & ~por_d_ff;
  end

  // wishbone decode, single-cycle answer, ack dropped after one cycle
  logic wb_req;
  logic wb_wr;
  logic wb_wr_b0;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_wr_b0 = wb_wr & wb_sel_i[0];

  always_comb begin
    irq_clr = SPD_IRQ_RST;
    if (wb_wr_b0 && wb_adr_i == SPD_OFF_IRQ_CLR) begin
      irq_clr = wb_dat_i[SPD_IRQ_W-1:0];
    end
  end

  // set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= SPD_IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_ff <= SPD_IRQ_RST;
    end else if (wb_wr_b0 && wb_adr_i == SPD_OFF_IRQ_EN) begin
      irq_en_ff <= wb_dat_i[SPD_IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_ff & irq_en_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= SPD_CTRL_RST;
    end else if (wb_wr_b0 && wb_adr_i == SPD_OFF_CTRL) begin
      ctrl_ff <= {31'h0000_0000, wb_dat_i[SPD_CTRL_STANDBY_BIT]};
    end
  end

  logic [31:0] rd_data;

  always_comb begin
    rd_data = SPD_RD_ZERO;
    case (wb_adr_i)
      SPD_OFF_CTRL: rd_data = ctrl_ff;
      SPD_OFF_STAT: begin
        rd_data[SPD_ST_THERM_BIT] = thermal_trip_latch_ff;
        rd_data[SPD_ST_OVERCUR_BIT] = overcurrent_latch_ff;
        rd_data[SPD_ST_POR_BIT] = sup_low;
        rd_data[SPD_ST_RUN_BIT] = run;
        rd_data[SPD_ST_A_ON_BIT] = a_on;
        rd_data[SPD_ST_B_ON_BIT] = b_on;
      end
      SPD_OFF_IRQ_STAT: rd_data[SPD_IRQ_W-1:0] = irq_stat_ff;
      SPD_OFF_IRQ_EN: rd_data[SPD_IRQ_W-1:0] = irq_en_ff;
      SPD_OFF_LEVEL: begin
        rd_data[SPD_LVL_A_LSB +: 2] = a_lvl;
        rd_data[SPD_LVL_B_LSB +: 2] = b_lvl;
      end
      default: rd_data = SPD_RD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= SPD_RD_ZERO;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : SPD_RD_ZERO;
    end
  end

endmodule : spd_core

// [common/spd_pkg.sv]
/*
  Constants for the stepper phase/current decode block: register map,
  field layout, reset values and current-level encoding.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
package spd_pkg;
  // register byte offsets
  localparam logic [7:0] SPD_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPD_OFF_STAT = 8'h04;
  localparam logic [7:0] SPD_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] SPD_OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] SPD_OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] SPD_OFF_LEVEL = 8'h14;

  // control fields
  localparam int SPD_CTRL_STANDBY_BIT = 0;
  localparam logic [31:0] SPD_CTRL_RST = 32'h0000_0000;

  // status fields
  localparam int SPD_ST_THERM_BIT = 0;
  localparam int SPD_ST_OVERCUR_BIT = 1;
  localparam int SPD_ST_POR_BIT = 2;
  localparam int SPD_ST_RUN_BIT = 3;
  localparam int SPD_ST_A_ON_BIT = 4;
  localparam int SPD_ST_B_ON_BIT = 5;

  // interrupt event bits
  localparam int SPD_IRQ_W = 3;
  localparam int SPD_IRQ_THERM_BIT = 0;
  localparam int SPD_IRQ_OVERCUR_BIT = 1;
  localparam int SPD_IRQ_POR_BIT = 2;
  localparam logic [SPD_IRQ_W-1:0] SPD_IRQ_RST = 3'h0;

  // level register fields: 2 bits per channel
  localparam int SPD_LVL_A_LSB = 0;
  localparam int SPD_LVL_B_LSB = 2;

  // input synchroniser depth
  localparam int SPD_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    SPD_LVL_OFF  = 2'b00,
    SPD_LVL_38   = 2'b01,
    SPD_LVL_71   = 2'b10,
    SPD_LVL_FULL = 2'b11
  } spd_level_e;

  localparam logic [31:0] SPD_RD_ZERO = 32'h0000_0000;
endpackage : spd_pkg

// [verif/spd_core_asserts.sv]
/* Pin-level assertions for spd_core.
   Sees only the core's ports; bound into every spd_core. */
`timescale 1ns/100ps
module spd_core_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chan_a_dir_i,
  input wire logic chan_a_level_sel_hi_i,
  input wire logic chan_a_level_sel_lo_i,
  input wire logic standby_n_i,
  input wire logic therm_trip_i,
  input wire logic overcur_trip_i,
  input wire logic supply_low_i,
  input wire logic chan_a_pos_out_o,
  input wire logic chan_a_neg_out_o,
  input wire logic chan_a_oe_o,
  input wire logic chan_b_oe_o,
  input wire logic [1:0] chan_a_level_o,
  input wire logic chop_oscillator_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // six cycles outlast the pin latency
  sequence s_a_full;
    (chan_a_level_sel_hi_i && chan_a_level_sel_lo_i)[*6] ##0 chan_a_oe_o;
  endsequence
  sequence s_trip_gone;
    therm_trip_i[*6] ##1 (!therm_trip_i && standby_n_i)[*8];
  endsequence
  a_level_full: assert property (s_a_full |-> chan_a_level_o == 2'h3)
    else $error("full level not decoded");
  a_off_hiz: assert property ((!chan_a_level_sel_hi_i && !chan_a_level_sel_lo_i)[*6]
    |-> !chan_a_oe_o && chan_a_level_o == 2'h0) else $error("off channel still driven");
  a_dir_high: assert property (chan_a_dir_i[*6] ##0 chan_a_oe_o
    |-> chan_a_pos_out_o && !chan_a_neg_out_o) else $error("bridge polarity wrong");
  a_standby_off: assert property ((!standby_n_i)[*6]
    |-> !chop_oscillator_en_o && !chan_a_oe_o && !chan_b_oe_o) else $error("runs in standby");
  // latch adds one cycle over the plain pin path
  a_therm_off: assert property (therm_trip_i[*7] |-> !chan_a_oe_o && !chan_b_oe_o)
    else $error("outputs on during thermal trip");
  a_therm_held: assert property (s_trip_gone |-> !chop_oscillator_en_o && !chan_a_oe_o)
    else $error("thermal latch released");
  a_supply_off: assert property (supply_low_i[*6] |-> !chan_a_oe_o && !chan_b_oe_o)
    else $error("outputs on with supply low");
  a_overcur_stop: assert property (overcur_trip_i[*7] |-> !chop_oscillator_en_o && !chan_b_oe_o)
    else $error("runs during overcurrent");
endmodule : spd_core_asserts
bind spd_core spd_core_asserts i_chk (.clk_i, .rst_i, .chan_a_dir_i, .chan_a_level_sel_hi_i,
  .chan_a_level_sel_lo_i, .standby_n_i, .therm_trip_i, .overcur_trip_i, .supply_low_i,
  .chan_a_pos_out_o, .chan_a_neg_out_o, .chan_a_oe_o, .chan_b_oe_o, .chan_a_level_o,
  .chop_oscillator_en_o);

// [verif/spd_host_model.sv]
/* Host pin driver: applies direction and level commands.
   Assumes supply_ok_i reports the motor supply at operating voltage. */
`timescale 1ns/100ps
module spd_host_model (
  input wire logic clk_i,
  input wire logic supply_ok_i,
  input wire logic [5:0] cmd_i,
  output logic a_dir_o = 1'b0,
  output logic [1:0] a_lvl_o = 2'h0,
  output logic b_dir_o = 1'b0,
  output logic [1:0] b_lvl_o = 2'h0
);
  always @(posedge clk_i) begin
    if (supply_ok_i) begin
      {b_dir_o, b_lvl_o, a_dir_o, a_lvl_o} <= cmd_i;
    end else begin
      {b_dir_o, b_lvl_o, a_dir_o, a_lvl_o} <= 6'h00;
    end
  end
endmodule : spd_host_model

// [verif/tb_top.sv]
/* Self-checking bench for spd_core with the host pin model.
   Assumes the core, checker and host model compile before it. */
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import spd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, standby_n_i = 1'b1, therm_trip_i = 1'b0;
  logic overcur_trip_i = 1'b0, supply_low_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, wb_dat_o, r = 32'hE7D38F58;
  logic wb_ack_o, irq_o;
  logic chan_a_pos_out_o, chan_a_neg_out_o, chan_a_oe_o, chop_oscillator_en_o;
  logic chan_b_pos_out_o, chan_b_neg_out_o, chan_b_oe_o;
  logic [1:0] chan_a_level_o, chan_b_level_o;
  wire chan_a_dir_i, chan_a_level_sel_hi_i, chan_a_level_sel_lo_i;
  wire chan_b_dir_i, chan_b_level_sel_hi_i, chan_b_level_sel_lo_i;
  int bad_count = 0, checked = 0, k;
  logic [63:0] q[$];
  logic [63:0] n;
  spd_host_model i_host (.clk_i, .supply_ok_i(!supply_low_i), .cmd_i(cmd), .a_dir_o(chan_a_dir_i),
    .a_lvl_o({chan_a_level_sel_hi_i, chan_a_level_sel_lo_i}), .b_dir_o(chan_b_dir_i),
    .b_lvl_o({chan_b_level_sel_hi_i, chan_b_level_sel_lo_i}));
  spd_core i_dut (.clk_i, .rst_i, .chan_a_dir_i, .chan_a_level_sel_hi_i, .chan_a_level_sel_lo_i,
    .chan_b_dir_i, .chan_b_level_sel_hi_i, .chan_b_level_sel_lo_i, .standby_n_i, .therm_trip_i,
    .overcur_trip_i, .supply_low_i, .chan_a_pos_out_o, .chan_a_neg_out_o, .chan_a_oe_o,
    .chan_b_pos_out_o, .chan_b_neg_out_o, .chan_b_oe_o, .chan_a_level_o, .chan_b_level_o,
    .chop_oscillator_en_o, .irq_o, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o);
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      bad_count++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  // expected value and mask noted before the read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    wb_xfer(a, 1'b0, 32'h0);
  endtask : rd
  always @(posedge clk_i) begin
    if (cyc && wb_ack_o && !we) begin
      n = q.pop_front();
      `CHK(wb_dat_o & n[63:32], n[31:0])
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(SPD_OFF_CTRL, SPD_CTRL_RST, 32'hFFFFFFFF);
    rd(SPD_OFF_IRQ_EN, 32'h0, 32'hFFFFFFFF);
    rd(8'h20, SPD_RD_ZERO, 32'hFFFFFFFF);
    wb_xfer(SPD_OFF_CTRL, 1'b1, 32'h1);
    wb_xfer(SPD_OFF_IRQ_EN, 1'b1, 32'h7);
    wb_xfer(SPD_OFF_IRQ_CLR, 1'b1, 32'h7);
    for (k = 0; k < 4; k++) begin
      r = xs(r);
      cmd <= {r[0], r[2:1], k[0], k[1:0]};
      repeat (12) @(posedge clk_i);
      rd(SPD_OFF_LEVEL, {28'h0, r[2:1], k[1:0]}, 32'hF);
      rd(SPD_OFF_STAT, {26'h0, r[2:1] != 2'h0, k[1:0] != 2'h0, 4'h0}, 32'h37);
      `CHK(chan_a_oe_o, k[1:0] != 2'h0)
      `CHK(chan_a_pos_out_o, (k[1:0] != 2'h0) & k[0])
      `CHK(chan_a_neg_out_o, (k[1:0] != 2'h0) & ~k[0])
      `CHK(chan_a_level_o, k[1:0])
      `CHK(chan_b_oe_o, r[2:1] != 2'h0)
      `CHK(chan_b_pos_out_o, (r[2:1] != 2'h0) & r[0])
      `CHK(chan_b_neg_out_o, (r[2:1] != 2'h0) & ~r[0])
      `CHK(chan_b_level_o, r[2:1])
      `CHK(chop_oscillator_en_o, 1'b1)
    end
    cmd <= 6'h0F;
    standby_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rd(SPD_OFF_STAT, 32'h0, 32'h37);
    rd(SPD_OFF_LEVEL, 32'h7, 32'hF);
    `CHK(chan_a_level_o, 2'h0)
    `CHK(chan_b_oe_o, 1'b0)
    `CHK(chop_oscillator_en_o, 1'b0)
    standby_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    for (k = 0; k < 2; k++) begin
      therm_trip_i <= (k == 0);
      overcur_trip_i <= (k == 1);
      repeat (8) @(posedge clk_i);
      therm_trip_i <= 1'b0;
      overcur_trip_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rd(SPD_OFF_STAT, 32'h1 << k, 32'h37);
      `CHK(irq_o, 1'b1)
      `CHK(chan_b_oe_o, 1'b0)
      `CHK(chop_oscillator_en_o, 1'b0)
      rd(SPD_OFF_IRQ_STAT, 32'h1 << k, 32'h7);
      wb_xfer(SPD_OFF_IRQ_CLR, 1'b1, 32'h7);
      `CHK(irq_o, 1'b0)
      standby_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      standby_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rd(SPD_OFF_STAT, 32'h30, 32'h37);
      `CHK(chop_oscillator_en_o, 1'b1)
    end
    wb_xfer(SPD_OFF_IRQ_EN, 1'b1, 32'h1);
    supply_low_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(SPD_OFF_STAT, 32'h4, 32'h37);
    `CHK(chan_a_oe_o, 1'b0)
    `CHK(irq_o, 1'b0)
    rd(SPD_OFF_IRQ_STAT, 32'h4, 32'h7);
    supply_low_i <= 1'b0;
    repeat (14) @(posedge clk_i);
    rd(SPD_OFF_STAT, 32'h30, 32'h37);
    print_verdict();
  end
endmodule : tb_top
